// ---- mirror_controller_host_link.sv ----
/*
 * Host-side link to a mirror-array display controller: init-run-park
 * sequencer, array-type and speed sampling, up to four 16-pair pixel
 * buses paced by the sampled link clock, and load/block control pins.
 * Assumes controller pins and the link clock are asynchronous to
 * I_SYS_CLK, and the pixel source and control inputs are on I_SYS_CLK.
 */
`timescale 1ns/1ps
module mirror_controller_host_link (
    input  wire logic                          I_SYS_CLK,
    input  wire logic                          I_RESET,
    input  wire logic                          I_CE,
    input  wire logic                          I_BOARD_RESET_N,
    input  wire logic                          I_LINK_CLK,
    input  wire logic [3:0]                    I_ARRAY_TYPE,
    input  wire logic [1:0]                    I_SPEED_SEL,
    input  wire logic [2:0]                    I_FW_VERSION,
    input  wire logic                          I_CTRL_IRQ,
    input  wire logic                          I_CONTROLLER_CONFIG_DONE,
    input  wire logic                          I_INIT_ACTIVE,
    input  wire logic                          I_MIRROR_CLK_ACTIVE,
    input  wire logic                          I_PIX_VALID,
    output logic                               O_PIX_READY,
    input  wire mirror_link_pkg::pix_word_t    I_PIX_DATA,
    input  wire mirror_link_pkg::load_ctl_t    I_LOAD_CTL,
    input  wire logic                          I_QUAD_ROW_LOAD,
    input  wire mirror_link_pkg::block_ctl_t   I_BLOCK_CTL,
    output mirror_link_pkg::bus_lane_t [3:0]   O_BUSES,
    output logic                               O_LINK_RATE_HIGH,
    output logic                               O_FOUR_BUSES,
    output logic                               O_CTRL_RESET_N,
    output logic                               O_POWER_FLOAT_N,
    output logic                               O_RUNNING,
    output mirror_link_pkg::load_ctl_t         O_LOAD_CTL,
    output logic                               O_QUAD_ROW_LOAD_N,
    output mirror_link_pkg::block_ctl_t        O_BLOCK_CTL,
    output mirror_link_pkg::status_t           O_STATUS
);
    import mirror_link_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    pin_in_t pins_raw;
    pin_in_t pins_meta;
    pin_in_t pins_sync;
    logic    link_clk_last;

    assign pins_raw = '{
        board_reset_n:     I_BOARD_RESET_N,
        link_clk:          I_LINK_CLK,
        array_type:        I_ARRAY_TYPE,
        speed_sel:         I_SPEED_SEL,
        fw_version:        I_FW_VERSION,
        irq:               I_CTRL_IRQ,
        config_done:       I_CONTROLLER_CONFIG_DONE,
        init_active:       I_INIT_ACTIVE,
        mirror_clk_active: I_MIRROR_CLK_ACTIVE
    };

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RESET)
        begin
            pins_meta     <= '0;
            pins_sync     <= '0;
            link_clk_last <= 1'b0;
        end
        else if (I_CE)
        begin
            pins_meta     <= pins_raw;
            pins_sync     <= pins_meta;
            link_clk_last <= pins_sync.link_clk;
        end
    end

    wire link_rise = pins_sync.link_clk & ~link_clk_last;

    // ------------------------------------------------------------------
    // Init-run-park sequencer
    // ------------------------------------------------------------------
    seq_state_t             state;
    seq_state_t             next_state;
    logic [SETTLE_BITS-1:0] settle_cnt;
    logic [3:0]             array_type;
    logic [1:0]             speed_sel;

    localparam logic [SETTLE_BITS-1:0] SETTLE_LAST =
        SETTLE_BITS'(SETTLE_CYCLES - 1);

    wire settle_done = (settle_cnt == SETTLE_LAST);
    wire running     = (state == ST_RUN);
    wire logic_clear = I_RESET | ~running;

    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_PARK:
                if (pins_sync.board_reset_n)
                    next_state = ST_SAMPLE;
            ST_SAMPLE:
                if (!pins_sync.board_reset_n)
                    next_state = ST_PARK;
                else if (settle_done)
                    next_state = ST_RUN;
            ST_RUN:
                if (!pins_sync.board_reset_n)
                    next_state = ST_PARK;
            default:
                next_state = ST_PARK;
        endcase
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RESET)
        begin
            state      <= ST_PARK;
            settle_cnt <= '0;
            array_type <= ARRAY_TYPE_RESET;
            speed_sel  <= SPEED_SEL_RESET;
        end
        else if (I_CE)
        begin
            state <= next_state;
            if (state != ST_SAMPLE)
                settle_cnt <= '0;
            else if (!settle_done)
                settle_cnt <= settle_cnt + 1'b1;
            if (state == ST_SAMPLE && settle_done)
            begin
                array_type <= pins_sync.array_type;
                speed_sel  <= pins_sync.speed_sel;
            end
        end
    end

    // ------------------------------------------------------------------
    // Bus count and link rate
    // ------------------------------------------------------------------
    wire is_large = (array_type == LARGE_ARRAY_TYPE);
    wire is_small = (array_type == SMALL_ARRAY_TYPE);

    // On a large array, any jumper code other than the low one selects the validated rate; other arrays stay low.
    wire [3:0] bus_mask =
        is_large ? FOUR_BUS_MASK :
        is_small ? TWO_BUS_MASK  : NO_BUS_MASK;

    assign O_FOUR_BUSES     = is_large;
    assign O_LINK_RATE_HIGH =
        is_large & (speed_sel != SPEED_SEL_LOW);
    assign O_RUNNING        = running;
    assign O_CTRL_RESET_N   = running;
    assign O_POWER_FLOAT_N  = (state != ST_PARK);

    // ------------------------------------------------------------------
    // Pixel path
    // ------------------------------------------------------------------
    logic      buf_in_ready;
    logic      buf_out_valid;
    pix_word_t buf_out_data;

    wire drain = link_rise & running;

    word_buffer #(
        .WIDTH (NUM_BUSES * LANE_BITS),
        .DEPTH (BUFFER_DEPTH)
    ) u_word_buffer (
        .i_clk       (I_SYS_CLK),
        .i_clear     (logic_clear),
        .i_ce        (I_CE),
        .i_in_valid  (I_PIX_VALID & running),
        .o_in_ready  (buf_in_ready),
        .i_in_data   (I_PIX_DATA),
        .o_out_valid (buf_out_valid),
        .i_out_ready (drain),
        .o_out_data  (buf_out_data)
    );

    assign O_PIX_READY = buf_in_ready & running;

    genvar b;
    generate
        for (b = 0; b < NUM_BUSES; b++)
        begin : g_bus
            wire on = bus_mask[b] & running;
            wire [LANE_BITS-1:0] next_pixels =
                on ? buf_out_data.lane[b] : '0;
            wire next_valid = on & drain & buf_out_valid;
            wire next_fwd   = on & pins_sync.link_clk;

            always_ff @(posedge I_SYS_CLK)
            begin
                if (logic_clear)
                begin
                    O_BUSES[b].pixels_pos  <= '0;
                    O_BUSES[b].pixels_neg  <= '1;
                    O_BUSES[b].fwd_clk_pos <= 1'b0;
                    O_BUSES[b].fwd_clk_neg <= 1'b1;
                    O_BUSES[b].valid_pos   <= 1'b0;
                    O_BUSES[b].valid_neg   <= 1'b1;
                end
                else if (I_CE)
                begin
                    O_BUSES[b].fwd_clk_pos <= next_fwd;
                    O_BUSES[b].fwd_clk_neg <= ~next_fwd;
                    if (drain)
                    begin
                        O_BUSES[b].pixels_pos <= next_pixels;
                        O_BUSES[b].pixels_neg <= ~next_pixels;
                        O_BUSES[b].valid_pos  <= next_valid;
                        O_BUSES[b].valid_neg  <= ~next_valid;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Load, block control and status
    // ------------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK)
    begin
        if (logic_clear)
        begin
            O_LOAD_CTL        <= '0;
            O_QUAD_ROW_LOAD_N <= 1'b1;
            O_BLOCK_CTL       <= '{default: 1'b0,
                                  paired_block_ctl_n: 1'b1,
                                  watchdog_enable_n: 1'b1};
        end
        else if (I_CE)
        begin
            O_LOAD_CTL        <= I_LOAD_CTL;
            O_QUAD_ROW_LOAD_N <= ~I_QUAD_ROW_LOAD;
            O_BLOCK_CTL       <= I_BLOCK_CTL;
        end
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RESET)
            O_STATUS <= '0;
        else if (I_CE)
        begin
            O_STATUS.array_type        <= pins_sync.array_type;
            O_STATUS.speed_sel         <= pins_sync.speed_sel;
            O_STATUS.fw_version        <= pins_sync.fw_version;
            O_STATUS.irq               <= pins_sync.irq;
            O_STATUS.config_done       <= pins_sync.config_done;
            O_STATUS.init_active       <= pins_sync.init_active;
            O_STATUS.mirror_clk_active <= pins_sync.mirror_clk_active;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RESET);

    park_float_a: assert property (
        I_CE && !pins_sync.board_reset_n |=> !O_POWER_FLOAT_N
    ) else $error("power float not low after board reset press");

    release_sample_a: assert property (
        state == ST_PARK && pins_sync.board_reset_n && I_CE
        |=> state == ST_SAMPLE && !O_CTRL_RESET_N
    ) else $error("sequencer did not leave park on release");

    ctrl_reset_hold_a: assert property (
        $rose(O_CTRL_RESET_N) |-> $past(settle_done) &&
            $past(state) == ST_SAMPLE
    ) else $error("controller reset released before sampling ended");

    type_sample_a: assert property (
        I_CE && state == ST_SAMPLE && settle_done &&
            pins_sync.board_reset_n
        |=> running && array_type == $past(pins_sync.array_type)
    ) else $error("array type not latched when entering run");

    large_buses_a: assert property (
        I_CE && drain && buf_out_valid && O_FOUR_BUSES
        |=> O_BUSES[2].valid_pos && O_BUSES[3].valid_pos
    ) else $error("large array not driving four buses");

    large_rate_a: assert property (
        I_CE && state == ST_SAMPLE && settle_done &&
            pins_sync.board_reset_n &&
            pins_sync.array_type == LARGE_ARRAY_TYPE
        |=> O_LINK_RATE_HIGH == ($past(pins_sync.speed_sel) != SPEED_SEL_LOW)
    ) else $error("large array rate does not follow jumpers");

    small_rate_a: assert property (
        I_CE && state == ST_SAMPLE && settle_done &&
            pins_sync.board_reset_n &&
            pins_sync.array_type == SMALL_ARRAY_TYPE
        |=> !O_LINK_RATE_HIGH && !O_FOUR_BUSES
    ) else $error("small array not fixed at the low rate");

    idle_upper_a: assert property (
        I_CE && !O_FOUR_BUSES |=> !O_BUSES[2].valid_pos &&
            !O_BUSES[3].valid_pos && !O_BUSES[2].fwd_clk_pos &&
            !O_BUSES[3].fwd_clk_pos
    ) else $error("bus C or D active on a small array");

    bus_valid_a: assert property (
        I_CE && drain && buf_out_valid && bus_mask[0]
        |=> O_BUSES[0].valid_pos && !O_BUSES[0].valid_neg
    ) else $error("word drained without valid on bus A");

    quad_load_a: assert property (
        I_CE && running ##1 running && I_CE
        |-> O_QUAD_ROW_LOAD_N == !$past(I_QUAD_ROW_LOAD)
    ) else $error("quad row load level not inverted");

    status_pass_a: assert property (
        I_CE [*3] ##1 1'b1 |-> O_STATUS.fw_version == $past(I_FW_VERSION, 3)
    ) else $error("firmware version not passed to status");

    run_large_c: cover property (running && is_large && O_LINK_RATE_HIGH);
    run_small_c: cover property (running && is_small);
    park_again_c: cover property (running ##1 state == ST_PARK);
    word_out_c: cover property (O_BUSES[3].valid_pos);

endmodule

// ---- mirror_link_pkg.sv ----
/*
 * Shared constants and carrier types for the mirror-array controller host
 * link: widths, array-type codes, speed encodings, sequencer states and
 * the packed structs that group the pins.
 * Assumes a 25 MHz system clock and that every user of these types imports
 * this package.
 */
package mirror_link_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 40;
    localparam int SETTLE_TIME_NS = 200;
    localparam int SETTLE_CYCLES  =
        (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_BITS    = 4;

    // ------------------------------------------------------------------
    // Widths and codes
    // ------------------------------------------------------------------
    localparam int LANE_BITS       = 16;
    localparam int NUM_BUSES       = 4;
    localparam int SMALL_BUSES     = 2;
    localparam int BUFFER_DEPTH    = 2;
    localparam int LINK_MHZ_LOW    = 400;
    localparam int LINK_MHZ_HIGH   = 480;

    localparam logic [3:0] LARGE_ARRAY_TYPE = 4'hf;
    localparam logic [3:0] SMALL_ARRAY_TYPE = 4'he;
    localparam logic [1:0] SPEED_SEL_LOW    = 2'h0;

    localparam logic [3:0] FOUR_BUS_MASK = 4'hf;
    localparam logic [3:0] TWO_BUS_MASK  = 4'h3;
    localparam logic [3:0] NO_BUS_MASK   = 4'h0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] ARRAY_TYPE_RESET = 4'h0;
    localparam logic [1:0] SPEED_SEL_RESET  = 2'h0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_PARK   = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_RUN    = 2'b11
    } seq_state_t;

    typedef struct packed {
        logic [LANE_BITS-1:0] pixels_pos;
        logic [LANE_BITS-1:0] pixels_neg;
        logic                 fwd_clk_pos;
        logic                 fwd_clk_neg;
        logic                 valid_pos;
        logic                 valid_neg;
    } bus_lane_t;

    typedef struct packed {
        logic [NUM_BUSES-1:0][LANE_BITS-1:0] lane;
    } pix_word_t;

    typedef struct packed {
        logic [1:0]  row_mode;
        logic [10:0] row_addr;
        logic        complement;
        logic        vertical_image_invert;
    } load_ctl_t;

    typedef struct packed {
        logic [3:0] block_addr;
        logic [1:0] block_mode;
        logic       paired_block_ctl_n;
        logic       watchdog_enable_n;
    } block_ctl_t;

    typedef struct packed {
        logic       board_reset_n;
        logic       link_clk;
        logic [3:0] array_type;
        logic [1:0] speed_sel;
        logic [2:0] fw_version;
        logic       irq;
        logic       config_done;
        logic       init_active;
        logic       mirror_clk_active;
    } pin_in_t;

    typedef struct packed {
        logic [3:0] array_type;
        logic [1:0] speed_sel;
        logic [2:0] fw_version;
        logic       irq;
        logic       config_done;
        logic       init_active;
        logic       mirror_clk_active;
    } status_t;

endpackage

// ---- word_buffer.sv ----
/*
 * Small flip-flop FIFO with valid and ready on both sides.
 * Assumes one clock; the clear input empties it synchronously.
 */
`timescale 1ns/1ps
module word_buffer #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 2
) (
    input  wire logic             i_clk,
    input  wire logic             i_clear,
    input  wire logic             i_ce,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int PTR_BITS = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PTR_BITS:0] FULL_COUNT = (PTR_BITS + 1)'(DEPTH);
    localparam logic [PTR_BITS-1:0] LAST_SLOT = PTR_BITS'(DEPTH - 1);

    logic [WIDTH-1:0]    store [DEPTH];
    logic [PTR_BITS-1:0] wr_ptr;
    logic [PTR_BITS-1:0] rd_ptr;
    logic [PTR_BITS:0]   count;

    wire push = i_in_valid & o_in_ready & i_ce;
    wire pop  = o_out_valid & i_out_ready & i_ce;
    wire [PTR_BITS-1:0] next_wr_ptr =
        (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
    wire [PTR_BITS-1:0] next_rd_ptr =
        (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;

    assign o_in_ready  = (count != FULL_COUNT);
    assign o_out_valid = (count != '0);
    assign o_out_data  = store[rd_ptr];

    always_ff @(posedge i_clk)
    begin
        if (i_clear)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (push)
            begin
                store[wr_ptr] <= i_in_data;
                wr_ptr        <= next_wr_ptr;
            end
            if (pop)
                rd_ptr <= next_rd_ptr;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end

endmodule

// ---- mirror_ctrl_model.sv ----
/*
 * Behavioural controller at the far end of the pixel buses: link clock
 * source and word capture.
 * Assumes the bench raises i_run to let the link clock run.
 */
`timescale 1ns/1ps
module mirror_ctrl_model (
    input  wire logic                             i_run,
    input  wire mirror_link_pkg::bus_lane_t [3:0] i_buses,
    output logic                                  o_link_clk
);
    import mirror_link_pkg::*;

    // ------------------------------------------------------------------
    // Link clock and capture
    // ------------------------------------------------------------------
    logic [67:0] got_q[$];
    int          bad_pairs = 0;

    initial
        o_link_clk = 1'b0;

    // The clock stops only while low, so every frame ends on a whole cycle.
    always
    begin
        #160;
        if (i_run || o_link_clk)
            o_link_clk = ~o_link_clk;
    end

    // Sampling on the falling forwarded edge keeps clear of data changes.
    always @(negedge i_buses[0].fwd_clk_pos)
    begin : capture
        logic [67:0] word;
        for (int b = 0; b < NUM_BUSES; b++)
        begin
            word[64+b]       = i_buses[b].valid_pos;
            word[16*b +: 16] = i_buses[b].pixels_pos;
            if (i_buses[b].pixels_neg !== ~i_buses[b].pixels_pos)
                bad_pairs++;
            if (i_buses[b].valid_neg !== ~i_buses[b].valid_pos)
                bad_pairs++;
        end
        if (word[67:64] != 4'h0)
            got_q.push_back(word);
    end
endmodule

// ---- mirror_controller_host_link_tb.sv ----
/*
 * Self-checking bench: sequencer, bus count, link rate, buffering, pins.
 * Assumes the controller model supplies the link clock and captures words.
 */
`timescale 1ns/1ps
module mirror_controller_host_link_tb;
    import mirror_link_pkg::*;

    logic            I_SYS_CLK = 1'b0;
    logic            I_RESET = 1'b1;
    logic            I_CE = 1'b1;
    logic            I_BOARD_RESET_N = 1'b0;
    logic            I_LINK_CLK;
    logic            link_run = 1'b0;
    logic [3:0]      I_ARRAY_TYPE = 4'hf;
    logic [1:0]      I_SPEED_SEL = 2'h1;
    logic [2:0]      I_FW_VERSION = 3'h0;
    logic            I_CTRL_IRQ = 1'b0;
    logic [2:0]      misc_pins = 3'h0;
    logic            I_PIX_VALID = 1'b0;
    logic            O_PIX_READY;
    pix_word_t       I_PIX_DATA = '0;
    load_ctl_t       I_LOAD_CTL = '0;
    logic            I_QUAD_ROW_LOAD = 1'b0;
    block_ctl_t      I_BLOCK_CTL = '0;
    bus_lane_t [3:0] O_BUSES;
    logic            O_LINK_RATE_HIGH;
    logic            O_FOUR_BUSES;
    logic            O_CTRL_RESET_N;
    logic            O_POWER_FLOAT_N;
    logic            O_RUNNING;
    load_ctl_t       O_LOAD_CTL;
    logic            O_QUAD_ROW_LOAD_N;
    block_ctl_t      O_BLOCK_CTL;
    status_t         O_STATUS;
    int              errors = 0;
    int              checks_done = 0;
    int              cycles = 0;

    mirror_controller_host_link mirror_controller_host_link_inst (
        .I_SYS_CLK(I_SYS_CLK), .I_RESET(I_RESET), .I_CE(I_CE),
        .I_BOARD_RESET_N(I_BOARD_RESET_N), .I_LINK_CLK(I_LINK_CLK),
        .I_ARRAY_TYPE(I_ARRAY_TYPE), .I_SPEED_SEL(I_SPEED_SEL),
        .I_FW_VERSION(I_FW_VERSION), .I_CTRL_IRQ(I_CTRL_IRQ),
        .I_CONTROLLER_CONFIG_DONE(misc_pins[2]),
        .I_INIT_ACTIVE(misc_pins[1]), .I_MIRROR_CLK_ACTIVE(misc_pins[0]),
        .I_PIX_VALID(I_PIX_VALID), .O_PIX_READY(O_PIX_READY),
        .I_PIX_DATA(I_PIX_DATA), .I_LOAD_CTL(I_LOAD_CTL),
        .I_QUAD_ROW_LOAD(I_QUAD_ROW_LOAD), .I_BLOCK_CTL(I_BLOCK_CTL),
        .O_BUSES(O_BUSES), .O_LINK_RATE_HIGH(O_LINK_RATE_HIGH),
        .O_FOUR_BUSES(O_FOUR_BUSES), .O_CTRL_RESET_N(O_CTRL_RESET_N),
        .O_POWER_FLOAT_N(O_POWER_FLOAT_N), .O_RUNNING(O_RUNNING),
        .O_LOAD_CTL(O_LOAD_CTL), .O_QUAD_ROW_LOAD_N(O_QUAD_ROW_LOAD_N),
        .O_BLOCK_CTL(O_BLOCK_CTL), .O_STATUS(O_STATUS)
    );

    mirror_ctrl_model mirror_ctrl_model_inst (
        .i_run(link_run), .i_buses(O_BUSES), .o_link_clk(I_LINK_CLK)
    );

    // ------------------------------------------------------------------
    // Clock, timeout and helpers
    // ------------------------------------------------------------------
    always #20 I_SYS_CLK = ~I_SYS_CLK;

    always @(posedge I_SYS_CLK)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors++;
            give_verdict;
        end
    end

    task automatic give_verdict;
        if (errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic chk_word(input string n, input logic [67:0] e,
                            input logic [67:0] g);
        checks_done++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge I_SYS_CLK);
    endtask

    function automatic pix_word_t mkword(input int k);
        pix_word_t w;
        for (int b = 0; b < NUM_BUSES; b++)
            w.lane[b] = 16'(4096 * b + k);
        return w;
    endfunction

    function automatic logic [67:0] expw(input int k, input logic [3:0] m);
        pix_word_t w;
        w = mkword(k);
        for (int b = 0; b < NUM_BUSES; b++)
            if (!m[b])
                w.lane[b] = 16'h0;
        return {m, w};
    endfunction

    // Ready depends on registers only, so it is settled at the falling edge.
    task automatic push(input pix_word_t w, output logic ok);
        I_PIX_DATA  = w;
        I_PIX_VALID = 1'b1;
        ok          = O_PIX_READY;
        cyc(1);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic startup(input logic [3:0] t, input logic [1:0] s);
        I_BOARD_RESET_N = 1'b0;
        I_ARRAY_TYPE    = t;
        I_SPEED_SEL     = s;
        cyc(5);
        chk_bit("float_n", 1'b0, O_POWER_FLOAT_N);
        chk_bit("pix_ready", 1'b0, O_PIX_READY);
        chk_word("block_idle", 68'(8'h3), 68'(O_BLOCK_CTL));
        I_BOARD_RESET_N = 1'b1;
        cyc(4);
        chk_bit("ctrl_reset_n", 1'b0, O_CTRL_RESET_N);
        repeat (50) if (O_RUNNING !== 1'b1) cyc(1);
        chk_bit("running", 1'b1, O_RUNNING);
        chk_bit("ctrl_reset_n", 1'b1, O_CTRL_RESET_N);
        chk_bit("float_n", 1'b1, O_POWER_FLOAT_N);
        chk_bit("four", t == LARGE_ARRAY_TYPE, O_FOUR_BUSES);
        chk_bit("rate", t == LARGE_ARRAY_TYPE && s != SPEED_SEL_LOW,
                O_LINK_RATE_HIGH);
    endtask

    task automatic stream_test(input logic [3:0] mask);
        logic ok;
        mirror_ctrl_model_inst.got_q.delete();
        cyc(20);
        for (int k = 0; k < 3; k++)
        begin
            push(mkword(k), ok);
            chk_bit("fill_ready", k < BUFFER_DEPTH, ok);
        end
        link_run = 1'b1;
        for (int k = 2; k < 4; k++)
        begin
            ok = 1'b0;
            repeat (80) if (ok !== 1'b1) push(mkword(k), ok);
        end
        I_PIX_VALID = 1'b0;
        cyc(80);
        link_run = 1'b0;
        cyc(20);
        chk_word("count", 68'd4,
                 68'(mirror_ctrl_model_inst.got_q.size()));
        for (int k = 0; k < 4; k++)
            chk_word("word", expw(k, mask),
                     mirror_ctrl_model_inst.got_q[k]);
        chk_word("pairs", 68'd0, 68'(mirror_ctrl_model_inst.bad_pairs));
    endtask

    task automatic pins_test;
        I_FW_VERSION    = 3'h5;
        I_CTRL_IRQ      = 1'b1;
        misc_pins       = 3'h5;
        I_QUAD_ROW_LOAD = 1'b1;
        I_LOAD_CTL      = 15'h5a3c;
        I_BLOCK_CTL     = 8'h9b;
        I_ARRAY_TYPE    = SMALL_ARRAY_TYPE;
        cyc(6);
        chk_word("status", 68'({4'he, 2'h1, 3'h5, 1'b1, 3'h5}),
                 68'(O_STATUS));
        chk_bit("quad_n", 1'b0, O_QUAD_ROW_LOAD_N);
        chk_word("load", 68'(15'h5a3c), 68'(O_LOAD_CTL));
        chk_word("block", 68'(8'h9b), 68'(O_BLOCK_CTL));
        chk_bit("four_kept", 1'b1, O_FOUR_BUSES);
        I_QUAD_ROW_LOAD = 1'b0;
        cyc(2);
        chk_bit("quad_n", 1'b1, O_QUAD_ROW_LOAD_N);
        I_CE            = 1'b0;
        I_QUAD_ROW_LOAD = 1'b1;
        cyc(3);
        chk_bit("ce_hold", 1'b1, O_QUAD_ROW_LOAD_N);
        I_CE = 1'b1;
        cyc(1);
        chk_bit("quad_n", 1'b0, O_QUAD_ROW_LOAD_N);
    endtask

    task automatic flush_test;
        logic ok;
        mirror_ctrl_model_inst.got_q.delete();
        for (int k = 7; k < 9; k++)
        begin
            push(mkword(k), ok);
            chk_bit("flush_fill", 1'b1, ok);
        end
        I_PIX_VALID = 1'b0;
        startup(SMALL_ARRAY_TYPE, 2'h1);
        link_run = 1'b1;
        cyc(40);
        link_run = 1'b0;
        cyc(10);
        chk_word("flushed", 68'd0,
                 68'(mirror_ctrl_model_inst.got_q.size()));
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        cyc(4);
        I_RESET = 1'b0;
        cyc(2);
        chk_bit("float_n", 1'b0, O_POWER_FLOAT_N);
        chk_bit("ctrl_reset_n", 1'b0, O_CTRL_RESET_N);
        chk_bit("quad_n", 1'b1, O_QUAD_ROW_LOAD_N);
        startup(LARGE_ARRAY_TYPE, 2'h1);
        stream_test(FOUR_BUS_MASK);
        pins_test;
        startup(LARGE_ARRAY_TYPE, SPEED_SEL_LOW);
        flush_test;
        stream_test(TWO_BUS_MASK);
        give_verdict;
    end
endmodule
